// ---- hw/asp_pkg.sv ----
/*
 * Constants, parameters and carrier types for the amplifier step protection and clip logic.
 * Assumes a single 10 MHz clock and an asynchronous active-high reset.
 */
// Functional notes
// - Converter error request low asserts the active-low amplifier shutdown.
// - Short low pulse from output monitor asserts amplifier shutdown.
// - Fault lamp lights when any monitored amplifier reports an open fuse.
// - Blown fuse only lights the lamp, never causes shutdown.
// - Eight identical fuse channels, 64 modules, combined into one flag.
// - Blown fuse indication stays dark while the transmitter is off.
// - Fine steps follow a binary count as input rises.
// - After all fine steps, next coarse step turns on and fine steps clear.
// - Full fine-step sum equals 31/32 of one coarse step.
// - Request for a nonexistent coarse step forces all fine steps on.
// - Peak hold taken from first unused coarse latch; high ORs ones into fine data.
// - Fine steps held on while peak hold persists, released when it ends.
// - Removed patch link keeps that amplifier off unless a valid substitution targets it or the test button patches it.
// - Up to three coarse outputs may be routed to spare high steps.
// - Momentary test button drives any patched driver input high.
// - Any shutdown source ORs into shutdown, which clears every step latch.
// - Latch output high turns amplifier on, low turns it off.
// - Shutdown held about 20 ms after power-up before release.
// - Cable interlock fault is a shutdown source.
package asp_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int POWERUP_HOLD_MS = 20;
    localparam int POWERUP_HOLD_CYCLES = POWERUP_HOLD_MS * (CLK_HZ / 1000);

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int FUSE_CHANNELS = 8;
    localparam int AMPS_PER_CHANNEL = 8;
    localparam int FINE_BITS = 5;
    localparam int COARSE_STEPS = 16;
    localparam int MAX_SUBST = 3;
    localparam int SYNC_STAGES = 3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [FINE_BITS-1:0] FINE_RESET = 5'h00;
    localparam logic [COARSE_STEPS-1:0] COARSE_RESET = 16'h0000;
    localparam logic [3:0] PATCH_NONE = 4'hF;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic convKillN;
        logic monitorKillN;
        logic ledKill;
        logic cableFault;
    } asp_faults_t;

    typedef struct packed {
        logic [COARSE_STEPS-1:0] coarse;
        logic [FINE_BITS-1:0] fine;
    } asp_steps_t;

    typedef struct packed {
        logic valid;
        logic [3:0] srcStep;
        logic [3:0] dstStep;
    } asp_subst_t;

endpackage : asp_pkg

// ---- hw/asp_sync.sv ----
/*
 * Three-stage input synchroniser with agreement filter for asynchronous inputs.
 * Assumes the input may change at any time relative to clk.
 */
module asp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // ****************************************************************
    // Stages
    // ****************************************************************
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dout <= RESET_VALUE;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    dout[i] <= stage3[i];
                end
            end
        end
    end

endmodule : asp_sync

// ---- hw/asp_pulse_catch.sv ----
/*
 * Catches short active-low pulses asynchronously and releases them synchronously.
 * Assumes pulses may be shorter than one clock period.
 */
module asp_pulse_catch (
    input wire logic clk,
    input wire logic reset,
    input wire logic pulseN,
    output logic caught
);

    // ****************************************************************
    // Pulse stretcher
    // ****************************************************************
    logic seen;
    logic seenSync1;
    logic seenSync2;
    logic clearSeen;
    logic clearHold;

    // Capture on the falling edge of the request itself
    always_ff @(negedge pulseN or posedge clearSeen) begin
        if (clearSeen) begin
            seen <= 1'b0;
        end else begin
            seen <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            clearHold <= 1'b1;
            seenSync1 <= 1'b0;
            seenSync2 <= 1'b0;
            caught <= 1'b0;
        end else begin
            clearHold <= 1'b0;
            seenSync1 <= seen;
            seenSync2 <= seenSync1;
            caught <= seenSync2;
        end
    end

    // Registered reset term gives the capture flop a real clear edge after power-on
    assign clearSeen = clearHold | caught;

endmodule : asp_pulse_catch

// ---- hw/asp_protect_clip.sv ----
/*
 * Shutdown gathering, step latches with clip, patch substitution, test button and fuse lamp.
 * Assumes fault and fuse inputs are asynchronous pins and step data comes from logic on clk.
 */
module asp_protect_clip #(
    parameter int POWERUP_CYCLES = asp_pkg::POWERUP_HOLD_CYCLES,
    parameter int COARSE = asp_pkg::COARSE_STEPS,
    parameter int FINE = asp_pkg::FINE_BITS,
    parameter int CHANNELS = asp_pkg::FUSE_CHANNELS,
    parameter int PER_CHANNEL = asp_pkg::AMPS_PER_CHANNEL
) (
    input wire logic clk,
    input wire logic reset,
    input wire asp_pkg::asp_faults_t faults,
    input wire logic stepLoad,
    input wire asp_pkg::asp_steps_t stepData,
    input wire logic [COARSE-1:0] patchLinkFitted,
    input wire asp_pkg::asp_subst_t [asp_pkg::MAX_SUBST-1:0] subst,
    input wire logic [3:0] peak_hold_tap,
    input wire logic [COARSE-1:0] testPatched,
    input wire logic single_amp_test_button,
    input wire logic transmitterOn,
    input wire logic [CHANNELS*PER_CHANNEL-1:0] fuseOpen,
    output logic amp_shutdown_n,
    output logic powerup_hold,
    output logic peakHoldN,
    output logic [COARSE-1:0] coarseDrive,
    output logic [FINE-1:0] fineDrive,
    output logic [CHANNELS-1:0] fuseChannelFault,
    output logic amp_fault_lamp
);

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    logic convKillN;
    logic ledKill;
    logic cableFault;
    logic monitorPulse;
    logic buttonSync;
    logic onSync;
    logic [CHANNELS*PER_CHANNEL-1:0] fuseSync;

    asp_sync #(.WIDTH(3), .RESET_VALUE(3'h4)) u_faultSync (
        .clk(clk),
        .reset(reset),
        .din({faults.convKillN, faults.ledKill, faults.cableFault}),
        .dout({convKillN, ledKill, cableFault})
    );

    asp_sync #(.WIDTH(2), .RESET_VALUE(2'h0)) u_miscSync (
        .clk(clk),
        .reset(reset),
        .din({single_amp_test_button, transmitterOn}),
        .dout({buttonSync, onSync})
    );

    asp_sync #(.WIDTH(CHANNELS*PER_CHANNEL)) u_fuseSync (
        .clk(clk),
        .reset(reset),
        .din(fuseOpen),
        .dout(fuseSync)
    );

    asp_pulse_catch u_monitorCatch (
        .clk(clk),
        .reset(reset),
        .pulseN(faults.monitorKillN),
        .caught(monitorPulse)
    );

    // ****************************************************************
    // Power-up hold
    // ****************************************************************
    logic [31:0] holdCount;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            holdCount <= 32'h00000000;
            powerup_hold <= 1'b1;
        end else if (holdCount < 32'(POWERUP_CYCLES - 1)) begin
            holdCount <= holdCount + 32'h00000001;
            powerup_hold <= 1'b1;
        end else begin
            powerup_hold <= 1'b0;
        end
    end

    // ****************************************************************
    // Shutdown gathering
    // ****************************************************************
    logic shutdown;

    // Fuse status deliberately absent from this OR
    assign shutdown = ~convKillN
        | monitorPulse
        | ledKill
        | cableFault
        | powerup_hold;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            amp_shutdown_n <= 1'b0;
        end else begin
            amp_shutdown_n <= ~shutdown;
        end
    end

    // ****************************************************************
    // Step latches
    // ****************************************************************
    logic [COARSE-1:0] coarseLatch;
    logic [FINE-1:0] fineLatch;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            coarseLatch <= asp_pkg::COARSE_RESET;
            fineLatch <= asp_pkg::FINE_RESET;
        end else if (shutdown) begin
            coarseLatch <= asp_pkg::COARSE_RESET;
            fineLatch <= asp_pkg::FINE_RESET;
        end else if (stepLoad) begin
            coarseLatch <= stepData.coarse;
            fineLatch <= stepData.fine;
        end
    end

    // ****************************************************************
    // Clip
    // ****************************************************************
    logic peakHold;

    // Tap moves with substitution, set externally
    assign peakHold = coarseLatch[peak_hold_tap];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            peakHoldN <= 1'b1;
            fineDrive <= asp_pkg::FINE_RESET;
        end else begin
            peakHoldN <= ~peakHold;
            // All ones on fine lines is 31/32 of a coarse step
            fineDrive <= fineLatch | {FINE{peakHold}};
        end
    end

    // ****************************************************************
    // Patch, substitution and test
    // ****************************************************************
    logic [COARSE-1:0] nextCoarseDrive;

    // Substitution only touches coarse outputs
    always_comb begin
        nextCoarseDrive = coarseLatch & patchLinkFitted;
        for (int s = 0; s < asp_pkg::MAX_SUBST; s++) begin
            if (subst[s].valid) begin
                nextCoarseDrive[subst[s].dstStep] = coarseLatch[subst[s].srcStep];
            end
        end
        if (buttonSync) begin
            nextCoarseDrive = nextCoarseDrive | testPatched;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            coarseDrive <= asp_pkg::COARSE_RESET;
        end else begin
            coarseDrive <= nextCoarseDrive;
        end
    end

    // ****************************************************************
    // Blown fuse summary
    // ****************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fuseChannelFault <= '0;
            amp_fault_lamp <= 1'b0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                fuseChannelFault[c] <= onSync & (|fuseSync[c*PER_CHANNEL +: PER_CHANNEL]);
            end
            amp_fault_lamp <= onSync & (|fuseSync);
        end
    end

endmodule : asp_protect_clip

// ---- dv/asp_far_model.sv ----
/*
 * Converter and output monitor requests toward the protection block.
 * Assumes commands arrive from the bench on the rising clock edge.
 */
module asp_far_model (
    input wire logic clk,
    input wire logic convErr,
    input wire logic vswrReq,
    output logic convKillN,
    output logic monitorKillN
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Requests
    // ****************************************************************
    assign convKillN = !convErr;
    // One process owns the monitor request line
    initial begin
        monitorKillN = 1'b1;
        forever begin
            @(posedge clk);
            if (vswrReq) begin
                #20 monitorKillN = 1'b0;
                #130 monitorKillN = 1'b1;
            end
        end
    end
endmodule : asp_far_model

// ---- dv/asp_protect_clip_assertions.sv ----
/*
 * Port checker for the protection and clip block.
 * Assumes it is bound to asp_protect_clip.
 */
module asp_protect_clip_assertions #(
    parameter int POWERUP_CYCLES = 10,
    parameter int COARSE = 16,
    parameter int FINE = 5,
    parameter int CHANNELS = 8,
    parameter int PER_CHANNEL = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire asp_pkg::asp_faults_t faults,
    input wire logic stepLoad,
    input wire asp_pkg::asp_steps_t stepData,
    input wire logic [COARSE-1:0] patchLinkFitted,
    input wire asp_pkg::asp_subst_t [asp_pkg::MAX_SUBST-1:0] subst,
    input wire logic [3:0] peak_hold_tap,
    input wire logic [COARSE-1:0] testPatched,
    input wire logic single_amp_test_button,
    input wire logic transmitterOn,
    input wire logic [CHANNELS*PER_CHANNEL-1:0] fuseOpen,
    input wire logic amp_shutdown_n,
    input wire logic powerup_hold,
    input wire logic peakHoldN,
    input wire logic [COARSE-1:0] coarseDrive,
    input wire logic [FINE-1:0] fineDrive,
    input wire logic [CHANNELS-1:0] fuseChannelFault,
    input wire logic amp_fault_lamp
);
    // ****************************************************************
    // Helpers and properties
    // ****************************************************************
    logic [COARSE-1:0] dstMask;
    logic [3:0] quiet;
    wire logic idle = faults.convKillN && faults.monitorKillN && !faults.ledKill
        && !faults.cableFault;
    always_comb begin
        dstMask = '0;
        for (int i = 0; i < asp_pkg::MAX_SUBST; i++) begin
            if (subst[i].valid) begin
                dstMask[subst[i].dstStep] = 1'b1;
            end
        end
    end
    wire logic [COARSE-1:0] keep = patchLinkFitted & ~testPatched & ~dstMask;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            quiet <= 4'h0;
        end else if (!idle || powerup_hold) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_take;
        stepLoad && amp_shutdown_n;
    endsequence
    sequence s_still;
        amp_shutdown_n && !stepLoad;
    endsequence
    sequence s_dead;
        !amp_shutdown_n && !single_amp_test_button;
    endsequence
    property p_conv_kill;
        $fell(faults.convKillN) |-> ##[1:6] !amp_shutdown_n;
    endproperty
    property p_monitor_kill;
        $fell(faults.monitorKillN) |-> ##[1:6] !amp_shutdown_n;
    endproperty
    property p_other_kill;
        $rose(faults.ledKill || faults.cableFault) |-> ##[1:6] !amp_shutdown_n;
    endproperty
    property p_quiet_run;
        quiet >= 4'h8 |-> amp_shutdown_n;
    endproperty
    property p_kill_clears;
        s_dead[*6] |-> coarseDrive == '0 && fineDrive == '0;
    endproperty
    property p_peak;
        s_take ##0 stepData.coarse[peak_hold_tap] ##1 s_still[*2] |=> !peakHoldN && fineDrive == '1;
    endproperty
    property p_fine;
        s_take ##0 !stepData.coarse[peak_hold_tap] ##1 s_still[*2]
            |=> peakHoldN && fineDrive == $past(stepData.fine, 3);
    endproperty
    property p_coarse;
        s_take ##1 s_still[*2] |=> (coarseDrive & keep) == ($past(stepData.coarse, 3) & keep);
    endproperty
    property p_lamp;
        (transmitterOn && |fuseOpen)[*7] |-> amp_fault_lamp;
    endproperty
    property p_dark;
        !transmitterOn[*7] |-> !amp_fault_lamp && fuseChannelFault == '0;
    endproperty
    property p_powerup;
        powerup_hold |-> !amp_shutdown_n;
    endproperty
    a_conv_kill: assert property (p_conv_kill) else $error("converter request missed");
    a_monitor_kill: assert property (p_monitor_kill) else $error("pulse missed");
    a_other_kill: assert property (p_other_kill) else $error("fault missed");
    a_quiet_run: assert property (p_quiet_run) else $error("spurious shutdown");
    a_kill_clears: assert property (p_kill_clears) else $error("drives left on");
    a_peak: assert property (p_peak) else $error("peak hold wrong");
    a_fine: assert property (p_fine) else $error("fine steps wrong");
    a_coarse: assert property (p_coarse) else $error("coarse steps wrong");
    a_lamp: assert property (p_lamp) else $error("lamp dark");
    a_dark: assert property (p_dark) else $error("lamp lit while off");
    a_powerup: assert property (p_powerup) else $error("hold without shutdown");
endmodule : asp_protect_clip_assertions

bind asp_protect_clip asp_protect_clip_assertions #(
    .POWERUP_CYCLES(POWERUP_CYCLES), .COARSE(COARSE), .FINE(FINE), .CHANNELS(CHANNELS),
    .PER_CHANNEL(PER_CHANNEL)
) i_chk (
    .clk, .reset, .faults, .stepLoad, .stepData, .patchLinkFitted, .subst, .peak_hold_tap,
    .testPatched, .single_amp_test_button, .transmitterOn, .fuseOpen, .amp_shutdown_n,
    .powerup_hold, .peakHoldN, .coarseDrive, .fineDrive, .fuseChannelFault, .amp_fault_lamp
);

// ---- dv/amp_step_protect_clip_logic_tb.sv ----
/*
 * Self-checking bench for the protection and clip block.
 * Assumes the package, design, far-side model and checker are compiled first.
 */
module amp_step_protect_clip_logic_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic convErr = 1'b0;
    logic vswrReq = 1'b0;
    logic ledKill = 1'b0;
    logic cableFault = 1'b0;
    logic stepLoad = 1'b0;
    logic button = 1'b0;
    logic txOn = 1'b0;
    logic [63:0] fuseOpen = '0;
    asp_pkg::asp_steps_t stepData = '0;
    asp_pkg::asp_subst_t [asp_pkg::MAX_SUBST-1:0] subst = 27'h000010E;
    logic convKillN, monitorKillN, shutN, hold, peakN, lamp;
    logic [15:0] coarse;
    logic [4:0] fine;
    logic [7:0] chan;
    asp_pkg::asp_faults_t faults;
    int failCount = 0;
    int compares = 0;
    int cycles = 0;
    assign faults = {convKillN, monitorKillN, ledKill, cableFault};
    asp_far_model i_far (.clk(clk), .convErr(convErr), .vswrReq(vswrReq),
        .convKillN(convKillN), .monitorKillN(monitorKillN));
    asp_protect_clip #(.POWERUP_CYCLES(10)) i_dut (.clk(clk), .reset(reset), .faults(faults),
        .stepLoad(stepLoad), .stepData(stepData), .patchLinkFitted(16'h3FFD), .subst(subst),
        .peak_hold_tap(4'hF), .testPatched(16'h2000), .single_amp_test_button(button),
        .transmitterOn(txOn), .fuseOpen(fuseOpen), .amp_shutdown_n(shutN), .powerup_hold(hold),
        .peakHoldN(peakN), .coarseDrive(coarse), .fineDrive(fine), .fuseChannelFault(chan),
        .amp_fault_lamp(lamp));
    initial begin
        forever #50 clk = ~clk;
    end
    // ****************************************************************
    // Tasks and scenarios
    // ****************************************************************
    task automatic chkVec(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : chkVec
    task automatic chkBit(input logic got, input logic exp, input string what);
        chkVec({15'h0000, got}, {15'h0000, exp}, what);
    endtask : chkBit
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic load(input logic [15:0] c, input logic [4:0] f);
        @(posedge clk);
        stepLoad <= 1'b1;
        stepData <= {c, f};
        @(posedge clk);
        stepLoad <= 1'b0;
        cyc(4);
    endtask : load
    task automatic completeRun;
        $display("compares %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : completeRun
    task automatic tPowerup;
        int n;
        n = 0;
        chkBit(shutN, 1'b0, "not held");
        while (hold === 1'b1 && n < 50) begin
            cyc(1);
            n++;
        end
        cyc(2);
        chkBit(shutN, 1'b1, "not released");
        $display("test powerup done");
    endtask : tPowerup
    task automatic tFuse;
        @(posedge clk) fuseOpen[37] <= 1'b1;
        cyc(10);
        chkBit(lamp, 1'b0, "lamp lit while off");
        @(posedge clk) txOn <= 1'b1;
        cyc(10);
        chkBit(lamp, 1'b1, "lamp dark");
        chkVec({8'h00, chan}, 16'h0010, "channel");
        chkBit(shutN, 1'b1, "fuse shut down");
        @(posedge clk) fuseOpen <= '0;
        cyc(10);
        chkBit(lamp, 1'b0, "lamp stuck");
        $display("test fuse done");
    endtask : tFuse
    task automatic tSteps;
        load(16'h0003, 5'h15);
        chkVec(coarse, 16'h4001, "coarse patch");
        chkVec({11'h000, fine}, 16'h0015, "fine count");
        load(16'h8007, 5'h00);
        chkBit(peakN, 1'b0, "no peak hold");
        chkVec({11'h000, fine}, 16'h001F, "fine not held");
        chkVec(coarse, 16'h4005, "coarse clip");
        load(16'h0004, 5'h03);
        chkBit(peakN, 1'b1, "peak stuck");
        chkVec({11'h000, fine}, 16'h0003, "fine after clip");
        $display("test steps done");
    endtask : tSteps
    task automatic tTest;
        @(posedge clk) button <= 1'b1;
        cyc(8);
        chkVec(coarse, 16'h2004, "test on");
        @(posedge clk) button <= 1'b0;
        cyc(8);
        chkVec(coarse, 16'h0004, "test off");
        $display("test button done");
    endtask : tTest
    task automatic tKill(input int src);
        logic seen;
        seen = 1'b0;
        load(16'h0001, 5'h07);
        @(posedge clk);
        convErr <= (src == 0);
        vswrReq <= (src == 1);
        ledKill <= (src == 2);
        cableFault <= (src == 3);
        @(posedge clk) vswrReq <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            seen = seen | (shutN === 1'b0);
        end
        chkBit(seen, 1'b1, "no shutdown");
        chkVec(coarse | {11'h000, fine}, 16'h0000, "not cleared");
        if (src != 1) begin
            load(16'h0002, 5'h01);
        end
        @(posedge clk);
        {convErr, ledKill, cableFault} <= 3'h0;
        cyc(12);
        chkBit(shutN, 1'b1, "stuck off");
        chkVec(coarse | {11'h000, fine}, 16'h0000, "load taken");
        $display("test shutdown %0d done", src);
    endtask : tKill
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failCount++;
            $display("wrong value at %0t: timeout", $time);
            completeRun();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        cyc(1);
        tPowerup();
        tFuse();
        tSteps();
        tTest();
        for (int s = 0; s < 4; s++) begin
            tKill(s);
        end
        completeRun();
    end
endmodule : amp_step_protect_clip_logic_tb
